// >>> verilog/mcr_register_bank.sv
`timescale 1ns/1ps

// Functional notes
// - Wide values split into high and low words
// - Writing 1234 clears stored accumulated energy
// - Broadcast sensor type to all three channels
// - Broadcast signed phase shift to three channels
// - Broadcast ratio integer part to three channels
// - Broadcast ratio fraction part to three channels
// - Scaling setting accepts zero to six
// - Demand window in minutes, default fifteen
// - Voltage multiplier scales voltage-derived quantities
// - Current multiplier scales current-derived quantities
// - Wiring one is delta, zero is wye
// - Line frequency register selects 50 or 60
// - Writing 1833 switches device to BACnet
// - Each channel has type and ratio registers
// - Switch control zero low, one high, default one
// - Switch control acts only when pulses disabled
// - Port function selects pulse energy source
// - Relay type sets pulse idle level
// - All registers are unsigned sixteen-bit words
// - Scaling setting maps to per-class factors
module mcr_register_bank #(
  parameter int PULSE_CYCLES = mcr_pkg::PULSE_CYCLES_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register write port
  input wire logic wr_en,
  input wire logic [mcr_pkg::AW-1:0] wr_addr,
  input wire logic [mcr_pkg::DW-1:0] wr_data,
  output logic wr_ack_reg,
  output logic wr_err_reg,
  // Register read port
  input wire logic rd_en,
  input wire logic [mcr_pkg::AW-1:0] rd_addr,
  output logic [mcr_pkg::DW-1:0] rd_data_reg,
  output logic rd_valid_reg,
  output logic rd_err_reg,
  // Metering core interface
  input wire logic [2*mcr_pkg::DW-1:0] energy_total,
  input wire logic real_pulse,
  input wire logic reactive_pulse,
  input wire logic apparent_pulse,
  output logic clear_accum_reg,
  output logic bacnet_mode_reg,
  // Configuration towards the metering core
  output logic [mcr_pkg::DW-1:0] demand_window_minutes_reg,
  output logic [mcr_pkg::DW-1:0] voltage_multiplier_reg,
  output logic [mcr_pkg::DW-1:0] current_multiplier_reg,
  output logic delta_mode_reg,
  output logic freq_50hz_reg,
  output logic signed [3:0] energy_exp_reg,
  output logic signed [3:0] amps_exp_reg,
  output logic signed [3:0] volts_exp_reg,
  output logic signed [3:0] pf_exp_reg,
  output logic [mcr_pkg::NCH*mcr_pkg::DW-1:0] chan_ratio_integer_reg,
  output logic [mcr_pkg::NCH*mcr_pkg::DW-1:0] chan_ratio_fraction_reg,
  output logic [mcr_pkg::NCH*mcr_pkg::DW-1:0] chan_phase_shift_reg,
  output logic [mcr_pkg::NCH-1:0] chan_rogowski_reg,
  // Port 1 output pin
  output logic port1_out_reg
);
  import mcr_pkg::*;

  // Stored configuration words
  logic [DW-1:0] meter_sync_reg;
  logic [DW-1:0] port1_switch_control_reg;
  logic [DW-1:0] all_type_reg, all_phase_reg, all_int_reg, all_frac_reg;
  logic [DW-1:0] data_scaling_select_reg;
  logic [DW-1:0] wiring_type_reg;
  logic [DW-1:0] line_frequency_select_reg;
  logic [DW-1:0] port1_function_reg;
  logic [DW-1:0] port1_relay_polarity_reg;
  logic [DW-1:0] chan_type_reg [NCH];
  logic [DW-1:0] snap_high_reg; // High word caught at low-word read
  // Pulse generator
  mcr_port_state_t port_state_reg, port_state_next;
  logic [31:0] pulse_cnt_reg;
  logic pulse_event;
  logic idle_level;
  // Decode helpers
  logic wr_valid_value;
  logic wr_mapped;
  logic [DW-1:0] rd_data_next;
  logic rd_mapped;
  logic [2:0] scale_idx;

  // Is the written value legal for the addressed register
  always_comb begin
    wr_mapped = 1'b1;
    wr_valid_value = 1'b1;
    case (wr_addr)
      OFS_ALL_TYPE: wr_valid_value = (wr_data == SENSOR_MV) || (wr_data == SENSOR_ROGOWSKI);
      OFS_SCALING: wr_valid_value = (wr_data <= SCALAR_MAX);
      OFS_WIRING: wr_valid_value = (wr_data == WIRING_WYE) || (wr_data == WIRING_DELTA);
      OFS_LINE_FREQ: wr_valid_value = (wr_data == FREQ_50) || (wr_data == FREQ_60);
      OFS_PORT1_FUNC: wr_valid_value = (wr_data == FUNC_NONE) || (wr_data == FUNC_REAL) ||
                                       (wr_data == FUNC_REACTIVE) || (wr_data == FUNC_APPARENT);
      OFS_PORT1_RELAY: wr_valid_value = (wr_data == RELAY_NORM_OPEN) || (wr_data == RELAY_NORM_CLOSED);
      OFS_SWITCH_CTRL: wr_valid_value = (wr_data <= SWITCH_DEF);
      OFS_METER_SYNC, OFS_CLEAR_ACC, OFS_ALL_PHASE, OFS_ALL_INT, OFS_ALL_FRAC,
      OFS_DEMAND, OFS_VOLT_MULT, OFS_AMP_MULT, OFS_PROTOCOL: wr_valid_value = 1'b1;
      default: begin
        // Per-channel words; type words are enumerated too
        wr_mapped = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (wr_addr == OFS_CH_INT[i] || wr_addr == OFS_CH_FRAC[i] || wr_addr == OFS_CH_PHASE[i]) begin
            wr_mapped = 1'b1;
          end
          if (wr_addr == OFS_CH_TYPE[i]) begin
            wr_mapped = 1'b1;
            wr_valid_value = (wr_data == SENSOR_MV) || (wr_data == SENSOR_ROGOWSKI);
          end
        end
      end
    endcase
  end

  // Write handshake: one-cycle answer after every write
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ack_reg <= 1'b0;
      wr_err_reg <= 1'b0;
    end else begin
      wr_ack_reg <= wr_en && wr_mapped && wr_valid_value;
      wr_err_reg <= wr_en && !(wr_mapped && wr_valid_value);
    end
  end

  // Global configuration words
  always_ff @(posedge mclk) begin
    if (reset) begin
      meter_sync_reg <= ZERO_WORD;
      port1_switch_control_reg <= SWITCH_DEF;
      demand_window_minutes_reg <= DEMAND_DEF;
      voltage_multiplier_reg <= MULT_DEF;
      current_multiplier_reg <= MULT_DEF;
      data_scaling_select_reg <= SCALING_DEF;
      wiring_type_reg <= WIRING_WYE;
      line_frequency_select_reg <= FREQ_60;
      port1_function_reg <= FUNC_NONE;
      port1_relay_polarity_reg <= RELAY_NORM_OPEN;
      all_type_reg <= SENSOR_MV;
      all_phase_reg <= ZERO_WORD;
      all_int_reg <= RATIO_INT_DEF;
      all_frac_reg <= ZERO_WORD;
    end else if (wr_en && wr_valid_value) begin
      // Rejected values leave the old setting in place
      case (wr_addr)
        OFS_METER_SYNC: meter_sync_reg <= wr_data;
        OFS_SWITCH_CTRL: port1_switch_control_reg <= wr_data;
        OFS_DEMAND: demand_window_minutes_reg <= wr_data;
        OFS_VOLT_MULT: voltage_multiplier_reg <= wr_data;
        OFS_AMP_MULT: current_multiplier_reg <= wr_data;
        OFS_SCALING: data_scaling_select_reg <= wr_data;
        OFS_WIRING: wiring_type_reg <= wr_data;
        OFS_LINE_FREQ: line_frequency_select_reg <= wr_data;
        OFS_PORT1_FUNC: port1_function_reg <= wr_data;
        OFS_PORT1_RELAY: port1_relay_polarity_reg <= wr_data;
        OFS_ALL_TYPE: all_type_reg <= wr_data;
        OFS_ALL_PHASE: all_phase_reg <= wr_data;
        OFS_ALL_INT: all_int_reg <= wr_data;
        OFS_ALL_FRAC: all_frac_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // Per-channel sensor words; broadcast and direct writes share one port
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      always_ff @(posedge mclk) begin
        if (reset) begin
          chan_type_reg[ch] <= SENSOR_MV;
          chan_ratio_integer_reg[ch*DW +: DW] <= RATIO_INT_DEF;
          chan_ratio_fraction_reg[ch*DW +: DW] <= ZERO_WORD;
          chan_phase_shift_reg[ch*DW +: DW] <= ZERO_WORD;
        end else if (wr_en && wr_valid_value) begin
          if (wr_addr == OFS_ALL_TYPE || wr_addr == OFS_CH_TYPE[ch]) begin
            chan_type_reg[ch] <= wr_data;
          end
          if (wr_addr == OFS_ALL_INT || wr_addr == OFS_CH_INT[ch]) begin
            chan_ratio_integer_reg[ch*DW +: DW] <= wr_data;
          end
          // Broadcast fraction lands in the fraction words, not the integer ones
          if (wr_addr == OFS_ALL_FRAC || wr_addr == OFS_CH_FRAC[ch]) begin
            chan_ratio_fraction_reg[ch*DW +: DW] <= wr_data;
          end
          if (wr_addr == OFS_ALL_PHASE || wr_addr == OFS_CH_PHASE[ch]) begin
            chan_phase_shift_reg[ch*DW +: DW] <= wr_data;
          end
        end
      end
      // Type decoded for the analogue front end
      always_ff @(posedge mclk) begin
        if (reset) begin
          chan_rogowski_reg[ch] <= 1'b0;
        end else begin
          chan_rogowski_reg[ch] <= (chan_type_reg[ch] == SENSOR_ROGOWSKI);
        end
      end
    end
  endgenerate

  // Command strobes: clear pulse and sticky protocol switch
  always_ff @(posedge mclk) begin
    if (reset) begin
      clear_accum_reg <= 1'b0;
      bacnet_mode_reg <= 1'b0;
    end else begin
      clear_accum_reg <= wr_en && (wr_addr == OFS_CLEAR_ACC) && (wr_data == CLEAR_KEY);
      if (wr_en && (wr_addr == OFS_PROTOCOL) && (wr_data == BACNET_KEY)) begin
        bacnet_mode_reg <= 1'b1;
      end
    end
  end

  // Decoded settings towards the metering core, one cycle behind the word
  assign scale_idx = data_scaling_select_reg[2:0];
  always_ff @(posedge mclk) begin
    if (reset) begin
      delta_mode_reg <= 1'b0;
      freq_50hz_reg <= 1'b0;
      energy_exp_reg <= ENERGY_EXP[3];
      amps_exp_reg <= AMPS_EXP[3];
      volts_exp_reg <= VOLTS_EXP[3];
      pf_exp_reg <= PF_EXP;
    end else begin
      delta_mode_reg <= (wiring_type_reg == WIRING_DELTA);
      freq_50hz_reg <= (line_frequency_select_reg == FREQ_50);
      energy_exp_reg <= ENERGY_EXP[scale_idx];
      amps_exp_reg <= AMPS_EXP[scale_idx];
      volts_exp_reg <= VOLTS_EXP[scale_idx];
      pf_exp_reg <= PF_EXP;
    end
  end

  // Read decode; the high energy word comes from the snapshot so a pair never tears
  always_comb begin
    rd_mapped = 1'b1;
    rd_data_next = ZERO_WORD;
    case (rd_addr)
      OFS_METER_SYNC: rd_data_next = meter_sync_reg;
      OFS_SWITCH_CTRL: rd_data_next = port1_switch_control_reg;
      OFS_ALL_TYPE: rd_data_next = all_type_reg;
      OFS_ALL_PHASE: rd_data_next = all_phase_reg;
      OFS_ALL_INT: rd_data_next = all_int_reg;
      OFS_ALL_FRAC: rd_data_next = all_frac_reg;
      OFS_SCALING: rd_data_next = data_scaling_select_reg;
      OFS_DEMAND: rd_data_next = demand_window_minutes_reg;
      OFS_VOLT_MULT: rd_data_next = voltage_multiplier_reg;
      OFS_AMP_MULT: rd_data_next = current_multiplier_reg;
      OFS_WIRING: rd_data_next = wiring_type_reg;
      OFS_LINE_FREQ: rd_data_next = line_frequency_select_reg;
      OFS_PORT1_FUNC: rd_data_next = port1_function_reg;
      OFS_PORT1_RELAY: rd_data_next = port1_relay_polarity_reg;
      OFS_ENERGY_LOW: rd_data_next = energy_total[DW-1:0];
      OFS_ENERGY_HIGH: rd_data_next = snap_high_reg;
      default: begin
        // Write-only commands and unknown words answer zero with an error
        rd_mapped = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (rd_addr == OFS_CH_INT[i]) begin
            rd_mapped = 1'b1;
            rd_data_next = chan_ratio_integer_reg[i*DW +: DW];
          end
          if (rd_addr == OFS_CH_FRAC[i]) begin
            rd_mapped = 1'b1;
            rd_data_next = chan_ratio_fraction_reg[i*DW +: DW];
          end
          if (rd_addr == OFS_CH_TYPE[i]) begin
            rd_mapped = 1'b1;
            rd_data_next = chan_type_reg[i];
          end
          if (rd_addr == OFS_CH_PHASE[i]) begin
            rd_mapped = 1'b1;
            rd_data_next = chan_phase_shift_reg[i*DW +: DW];
          end
        end
      end
    endcase
  end

  // Read answer, one cycle after the strobe; all words are 16 bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data_reg <= ZERO_WORD;
      rd_valid_reg <= 1'b0;
      rd_err_reg <= 1'b0;
      snap_high_reg <= ZERO_WORD;
    end else begin
      rd_valid_reg <= rd_en;
      rd_err_reg <= rd_en && !rd_mapped;
      if (rd_en) begin
        rd_data_reg <= rd_data_next;
      end
      if (rd_en && rd_addr == OFS_ENERGY_LOW) begin
        snap_high_reg <= energy_total[WORD_SHIFT +: DW];
      end
    end
  end

  // Port 1 mode: switch while pulses disabled, else pulses from the selected source
  always_comb begin
    case (port1_function_reg)
      FUNC_REAL: pulse_event = real_pulse;
      FUNC_REACTIVE: pulse_event = reactive_pulse;
      FUNC_APPARENT: pulse_event = apparent_pulse;
      default: pulse_event = 1'b0;
    endcase
    idle_level = (port1_relay_polarity_reg == RELAY_NORM_OPEN);
    port_state_next = port_state_reg;
    case (port_state_reg)
      MCR_SWITCH: if (port1_function_reg != FUNC_NONE) begin
        port_state_next = MCR_IDLE;
      end
      MCR_IDLE: begin
        if (port1_function_reg == FUNC_NONE) begin
          port_state_next = MCR_SWITCH;
        end else if (pulse_event) begin
          port_state_next = MCR_PULSE;
        end
      end
      MCR_PULSE: begin
        // A pulse arriving mid-pulse is dropped; width is fixed
        if (port1_function_reg == FUNC_NONE) begin
          port_state_next = MCR_SWITCH;
        end else if (pulse_cnt_reg == 32'(PULSE_CYCLES - 1)) begin
          port_state_next = MCR_IDLE;
        end
      end
      default: port_state_next = MCR_SWITCH;
    endcase
  end

  // Pulse state and width counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      port_state_reg <= MCR_SWITCH;
      pulse_cnt_reg <= '0;
    end else begin
      port_state_reg <= port_state_next;
      pulse_cnt_reg <= (port_state_reg == MCR_PULSE) ? pulse_cnt_reg + 32'd1 : '0;
    end
  end

  // Pin driver
  always_ff @(posedge mclk) begin
    if (reset) begin
      port1_out_reg <= SWITCH_DEF[0];
    end else begin
      case (port_state_reg)
        MCR_SWITCH: port1_out_reg <= port1_switch_control_reg[0];
        MCR_IDLE: port1_out_reg <= idle_level;
        MCR_PULSE: port1_out_reg <= !idle_level;
        default: port1_out_reg <= SWITCH_DEF[0];
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_clear_key_pulse: assert property (wr_en && wr_addr == OFS_CLEAR_ACC && wr_data == CLEAR_KEY |=> clear_accum_reg)
    else $error("clear key did not raise clear pulse");
  chk_clear_wrong_key: assert property (clear_accum_reg |-> $past(wr_en) && $past(wr_data) == CLEAR_KEY)
    else $error("clear pulse without the key");
  chk_broadcast_type: assert property (wr_en && wr_addr == OFS_ALL_TYPE && wr_data == SENSOR_ROGOWSKI
    |=> ##1 (chan_rogowski_reg == 3'b111))
    else $error("broadcast type not on all channels");
  chk_broadcast_phase: assert property (wr_en && wr_addr == OFS_ALL_PHASE |=>
    chan_phase_shift_reg == {3{$past(wr_data)}})
    else $error("broadcast phase shift mismatch");
  chk_broadcast_int: assert property (wr_en && wr_addr == OFS_ALL_INT |=>
    chan_ratio_integer_reg == {3{$past(wr_data)}})
    else $error("broadcast integer part mismatch");
  chk_broadcast_frac: assert property (wr_en && wr_addr == OFS_ALL_FRAC |=>
    chan_ratio_fraction_reg == {3{$past(wr_data)}} && $stable(chan_ratio_integer_reg))
    else $error("broadcast fraction part mismatch");
  chk_scaling_reject: assert property (wr_en && wr_addr == OFS_SCALING && wr_data > SCALAR_MAX |=>
    $stable(data_scaling_select_reg) && wr_err_reg)
    else $error("illegal scaling setting accepted");
  chk_scaling_exp: assert property (wr_en && wr_addr == OFS_SCALING && wr_data == 16'h0000 |=> ##1
    energy_exp_reg == -4'sd5 && amps_exp_reg == -4'sd2)
    else $error("scaling exponent wrong for setting zero");
  chk_bacnet_switch: assert property (wr_en && wr_addr == OFS_PROTOCOL && wr_data == BACNET_KEY |=>
    bacnet_mode_reg)
    else $error("protocol key ignored");
  chk_switch_follow: assert property (port_state_reg == MCR_SWITCH |=>
    port1_out_reg == $past(port1_switch_control_reg[0]))
    else $error("switch control not driving pin");
  // Pin lags the polarity word by one cycle, so compare with last cycle's word
  chk_pulse_idle: assert property (port_state_reg == MCR_IDLE [*2] |->
    port1_out_reg == $past(port1_relay_polarity_reg == RELAY_NORM_OPEN))
    else $error("pulse idle level wrong");
  chk_word_pair: assert property (rd_en && rd_addr == OFS_ENERGY_LOW ##1
    rd_en && rd_addr == OFS_ENERGY_HIGH |=> rd_data_reg == $past(energy_total[WORD_SHIFT +: DW], 2))
    else $error("high word not from snapshot");

  cov_clear: cover property (clear_accum_reg);
  cov_broadcast: cover property (wr_en && wr_addr == OFS_ALL_INT ##1 wr_ack_reg);
  cov_pulse: cover property (port_state_reg == MCR_IDLE ##1 port_state_reg == MCR_PULSE);
  cov_bacnet: cover property ($rose(bacnet_mode_reg));

endmodule : mcr_register_bank

// >>> verilog/mcr_pkg.sv
package mcr_pkg;

  // Bus geometry: every holding register is one unsigned 16-bit word
  localparam int AW = 16;
  localparam int DW = 16;
  localparam int NCH = 3;
  localparam int WORD_SHIFT = 16;

  // Register offsets
  localparam logic [15:0] OFS_METER_SYNC = 16'h0080;
  localparam logic [15:0] OFS_CLEAR_ACC = 16'h0fe1;
  localparam logic [15:0] OFS_SWITCH_CTRL = 16'h1131;
  localparam logic [15:0] OFS_ALL_TYPE = 16'h11ac;
  localparam logic [15:0] OFS_ALL_PHASE = 16'h11f6;
  localparam logic [15:0] OFS_ALL_INT = 16'h11f7;
  localparam logic [15:0] OFS_ALL_FRAC = 16'h11f8;
  localparam logic [15:0] OFS_SCALING = 16'h11f9;
  localparam logic [15:0] OFS_DEMAND = 16'h11fa;
  localparam logic [15:0] OFS_VOLT_MULT = 16'h11fb;
  localparam logic [15:0] OFS_AMP_MULT = 16'h11fc;
  localparam logic [15:0] OFS_WIRING = 16'h11fe;
  localparam logic [15:0] OFS_LINE_FREQ = 16'h1200;
  localparam logic [15:0] OFS_PROTOCOL = 16'h1203;
  localparam logic [15:0] OFS_PORT1_FUNC = 16'h13f5;
  localparam logic [15:0] OFS_PORT1_RELAY = 16'h13f6;
  localparam logic [15:0] OFS_ENERGY_LOW = 16'h0fa0;
  localparam logic [15:0] OFS_ENERGY_HIGH = 16'h0fa1;
  localparam logic [15:0] OFS_CH_INT [NCH] = '{16'h2773, 16'h27d7, 16'h283b};
  localparam logic [15:0] OFS_CH_FRAC [NCH] = '{16'h2774, 16'h27d8, 16'h283c};
  localparam logic [15:0] OFS_CH_TYPE [NCH] = '{16'h278c, 16'h27f0, 16'h2854};
  localparam logic [15:0] OFS_CH_PHASE [NCH] = '{16'h27d6, 16'h283a, 16'h289e};

  // Command keys and enumerated values
  localparam logic [15:0] CLEAR_KEY = 16'h04d2;
  localparam logic [15:0] BACNET_KEY = 16'h0729;
  localparam logic [15:0] SENSOR_MV = 16'h0001;
  localparam logic [15:0] SENSOR_ROGOWSKI = 16'h0002;
  localparam logic [15:0] WIRING_WYE = 16'h0000;
  localparam logic [15:0] WIRING_DELTA = 16'h0001;
  localparam logic [15:0] FREQ_50 = 16'h0032;
  localparam logic [15:0] FREQ_60 = 16'h003c;
  localparam logic [15:0] FUNC_NONE = 16'h0000;
  localparam logic [15:0] FUNC_REAL = 16'habe1;
  localparam logic [15:0] FUNC_REACTIVE = 16'habe8;
  localparam logic [15:0] FUNC_APPARENT = 16'habeb;
  localparam logic [15:0] RELAY_NORM_OPEN = 16'h0000;
  localparam logic [15:0] RELAY_NORM_CLOSED = 16'h0001;
  localparam logic [15:0] SCALAR_MAX = 16'h0006;

  // Reset values
  localparam logic [15:0] DEMAND_DEF = 16'h000f;
  localparam logic [15:0] SWITCH_DEF = 16'h0001;
  localparam logic [15:0] SCALING_DEF = 16'h0003;
  localparam logic [15:0] MULT_DEF = 16'h0001;
  localparam logic [15:0] RATIO_INT_DEF = 16'h0001;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // Decimal exponents of the scaling factor per setting 0..6
  localparam logic signed [3:0] ENERGY_EXP [7] = '{-4'sd5, -4'sd3, -4'sd2, -4'sd1, 4'sd0, 4'sd1, 4'sd2};
  localparam logic signed [3:0] AMPS_EXP [7] = '{-4'sd2, -4'sd1, -4'sd1, -4'sd1, 4'sd0, 4'sd0, 4'sd0};
  localparam logic signed [3:0] VOLTS_EXP [7] = '{-4'sd1, -4'sd1, -4'sd1, -4'sd1, 4'sd0, 4'sd0, 4'sd0};
  localparam logic signed [3:0] PF_EXP = -4'sd2;

  // Pulse output timing
  localparam int PULSE_MS = 100;
  localparam int CLK_KHZ = 125000;
  localparam int PULSE_CYCLES_DEF = PULSE_MS * CLK_KHZ;

  // Port 1 output behaviour
  typedef enum logic [1:0] {
    MCR_SWITCH = 2'b00,
    MCR_IDLE = 2'b01,
    MCR_PULSE = 2'b10
  } mcr_port_state_t;

endpackage : mcr_pkg

// >>> bench/mcr_core_model.sv
`timescale 1ns/1ps
// Metering core stand-in: energy grows by a fixed step on each pulse
module mcr_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pulse requests in, energy and pulses out
  input wire logic [2:0] fire,
  output logic [31:0] energy_total,
  output logic [2:0] pulse
);
  // Step crosses the word boundary, so a torn two-word read shows up
  always_ff @(posedge mclk) begin
    if (reset) begin
      energy_total <= 32'h0003_1395;
      pulse <= 3'h0;
    end else begin
      pulse <= fire;
      energy_total <= energy_total + (|fire ? 32'h0001_2345 : 32'h0000_0000);
    end
  end
endmodule : mcr_core_model

// >>> bench/tb_meter_config_register_bank.sv
`timescale 1ns/1ps
module tb_meter_config_register_bank;
  import mcr_pkg::*;
  // Bench-driven inputs, valued at time zero
  logic mclk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [15:0] wr_addr = 16'h0000, wr_data = 16'h0000, rd_addr = 16'h0000, v, x;
  logic [15:0] sd = 16'h52ac;
  logic [2:0] fire = 3'h0, pl, rogo;
  // Bank outputs
  logic [15:0] rd_data_reg, dem, vm, cm;
  logic [31:0] energy_total, e;
  logic [47:0] r_int, r_frac, r_ph;
  logic wr_ack_reg, wr_err_reg, rd_valid_reg, rd_err_reg, clr, bac, dl, f50, p1;
  logic signed [3:0] ee, ae, ve, pe;
  // Expected read answers, oldest first: {err, data}
  logic [16:0] expq[$];
  int fails = 0, n_checks = 0, n_clr = 0, k;
  always #4 mclk = ~mclk;
  mcr_core_model core (.mclk, .reset, .fire, .energy_total, .pulse(pl));
  // Short pulse width keeps the port scenarios brief
  mcr_register_bank #(.PULSE_CYCLES(8)) dut (.mclk, .reset, .wr_en, .wr_addr, .wr_data, .wr_ack_reg,
    .wr_err_reg, .rd_en, .rd_addr, .rd_data_reg, .rd_valid_reg, .rd_err_reg, .energy_total,
    .real_pulse(pl[0]), .reactive_pulse(pl[1]), .apparent_pulse(pl[2]), .clear_accum_reg(clr),
    .bacnet_mode_reg(bac), .demand_window_minutes_reg(dem), .voltage_multiplier_reg(vm),
    .current_multiplier_reg(cm), .delta_mode_reg(dl), .freq_50hz_reg(f50), .energy_exp_reg(ee),
    .amps_exp_reg(ae), .volts_exp_reg(ve), .pf_exp_reg(pe), .chan_ratio_integer_reg(r_int),
    .chan_ratio_fraction_reg(r_frac), .chan_phase_shift_reg(r_ph), .chan_rogowski_reg(rogo),
    .port1_out_reg(p1));
  // Compare and count
  task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  function automatic logic [15:0] lfsr();
    sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
    return sd;
  endfunction : lfsr
  // Write entered at a falling edge; the one-cycle answer is seen at the next falling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic err);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk) wr_en = 1'b0;
    chk("wr_ack", 48'(!err), 48'(wr_ack_reg));
    chk("wr_err", 48'(err), 48'(wr_err_reg));
    @(negedge mclk);
  endtask : wr
  // Read: expectation noted now, compared by the watcher below
  task automatic rd(input logic [15:0] a, input logic [16:0] ex);
    rd_en = 1'b1;
    rd_addr = a;
    expq.push_back(ex);
    @(negedge mclk) rd_en = 1'b0;
    @(negedge mclk);
  endtask : rd
  // Fire one event and count cycles the pin leaves its idle level
  task automatic pulse(input logic [2:0] f, input logic idl, input int n);
    int c = 0;
    @(negedge mclk) fire = f;
    @(negedge mclk) fire = 3'h0;
    repeat (16) begin
      @(negedge mclk);
      c += int'(p1 !== idl);
    end
    chk("pulse_len", 48'(n), 48'(c));
  endtask : pulse
  // Watcher: clear pulses counted, read answers matched in order
  always @(negedge mclk) begin
    if (clr === 1'b1) n_clr++;
    if (rd_valid_reg === 1'b1 && expq.size() > 0) chk("rd_data", 48'(expq.pop_front()), 48'({rd_err_reg, rd_data_reg}));
  end
  task automatic test_done();
    chk("rd_left", 48'h0, 48'(expq.size()));
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    chk("port1", 48'h1, 48'(p1));
    chk("demand", 48'hf, 48'(dem));
    rd(OFS_DEMAND, 17'h0000f);
    rd(OFS_SWITCH_CTRL, 17'h00001);
    rd(16'h1234, 17'h10000);
    v = lfsr();
    wr(OFS_ALL_INT, v, 1'b0);
    chk("ratio_int", {3{v}}, r_int);
    rd(OFS_CH_INT[2], {1'b0, v});
    v = lfsr();
    wr(OFS_ALL_FRAC, v, 1'b0);
    chk("ratio_frac", {3{v}}, r_frac);
    wr(OFS_ALL_PHASE, 16'hfe0c, 1'b0);
    chk("phase", {3{16'hfe0c}}, r_ph);
    wr(OFS_ALL_TYPE, 16'h0002, 1'b0);
    chk("rogowski", 48'h7, 48'(rogo));
    wr(OFS_CH_TYPE[1], 16'h0001, 1'b0);
    wr(OFS_ALL_TYPE, 16'h0003, 1'b1);
    chk("rogowski", 48'h5, 48'(rogo));
    // Every setting, then one past the top which must be refused
    for (int s = 0; s < 8; s++) begin
      k = (s > 6) ? 6 : s;
      x = {4'(k == 0 ? -5 : k - 4), 4'(k == 0 ? -2 : k < 4 ? -1 : 0), 4'(k < 4 ? -1 : 0), 4'he};
      wr(OFS_SCALING, 16'(s), s == 7);
      chk("exps", 48'(x), 48'({ee, ae, ve, pe}));
    end
    wr(OFS_WIRING, 16'h0001, 1'b0);
    wr(OFS_WIRING, 16'h0002, 1'b1);
    chk("delta", 48'h1, 48'(dl));
    wr(OFS_LINE_FREQ, 16'h0032, 1'b0);
    chk("freq50", 48'h1, 48'(f50));
    v = lfsr();
    wr(OFS_VOLT_MULT, v, 1'b0);
    wr(OFS_AMP_MULT, ~v, 1'b0);
    chk("mults", 48'({v, ~v}), 48'({vm, cm}));
    wr(OFS_CLEAR_ACC, 16'h04d3, 1'b0);
    wr(OFS_CLEAR_ACC, 16'h04d2, 1'b0);
    wr(OFS_PROTOCOL, 16'h0729, 1'b0);
    @(negedge mclk);
    chk("clears", 48'h1, 48'(n_clr));
    chk("bacnet", 48'h1, 48'(bac));
    // Energy moves between the low and high reads; high must be the snapshot
    e = energy_total;
    rd(OFS_ENERGY_LOW, {1'b0, e[15:0]});
    pulse(3'h1, 1'b1, 0);
    rd(OFS_ENERGY_HIGH, {1'b0, e[31:16]});
    wr(OFS_SWITCH_CTRL, 16'h0000, 1'b0);
    @(negedge mclk);
    chk("port1", 48'h0, 48'(p1));
    wr(OFS_PORT1_FUNC, 16'habe1, 1'b0);
    pulse(3'h2, 1'b1, 0);
    pulse(3'h1, 1'b1, 8);
    wr(OFS_PORT1_FUNC, 16'habe8, 1'b0);
    pulse(3'h2, 1'b1, 8);
    wr(OFS_PORT1_FUNC, 16'habeb, 1'b0);
    wr(OFS_PORT1_FUNC, 16'habe2, 1'b1);
    wr(OFS_PORT1_RELAY, 16'h0001, 1'b0);
    pulse(3'h4, 1'b0, 8);
    // Back-to-back low then high read; the master rebuilds the raw total from the pair
    e = energy_total;
    rd_en = 1'b1;
    rd_addr = OFS_ENERGY_LOW;
    expq.push_back({1'b0, e[15:0]});
    @(negedge mclk) rd_addr = OFS_ENERGY_HIGH;
    expq.push_back({1'b0, e[31:16]});
    @(negedge mclk) rd_en = 1'b0;
    @(negedge mclk);
    chk("rebuilt", 48'(e), 48'(rd_data_reg) * 48'd65536 + 48'(e[15:0]));
    test_done();
  end
  // Watchdog, far beyond the roughly 170 cycles the run needs
  initial begin
    #100000;
    fails++;
    test_done();
  end
endmodule : tb_meter_config_register_bank
